// ===== core/cirp_pkg.sv
// constants for the indexed controller register port
// assumes an 8-bit special-function bus on page 1 and a 16-bit indexed controller bus
// Notes on behaviour
// - index pointer selects controller register
// - data byte pair forms 16-bit window
// - low write increments pointer in interface ranges
// - irq flag bit 4, read-only
// - flag reads one while interrupt pending
// - flag follows controller, clears by hardware
// - control/test/status reachable directly and indexed
// - decode data low, test, control addresses
// - control 0x00 reset 0x0001, status, timing
// - timing writes need config change enable
`default_nettype none
package cirp_pkg;
  localparam logic [7:0]  SFR_DATA_LOW    = 8'hd8;
  localparam logic [7:0]  SFR_DATA_HIGH   = 8'hd9;
  localparam logic [7:0]  SFR_INDEX       = 8'hda;
  localparam logic [7:0]  SFR_TEST        = 8'hdb;
  localparam logic [7:0]  SFR_STATUS      = 8'hc0;
  localparam logic [7:0]  SFR_CONTROL     = 8'hf8;
  localparam logic [7:0]  SFR_PAGE_CAN    = 8'h01;
  localparam logic [7:0]  IDX_CONTROL     = 8'h00;
  localparam logic [7:0]  IDX_STATUS      = 8'h01;
  localparam logic [7:0]  IDX_BIT_TIMING  = 8'h03;
  localparam logic [7:0]  IDX_TEST        = 8'h05;
  localparam logic [7:0]  IF_A_FIRST      = 8'h08;
  localparam logic [7:0]  IF_A_LAST       = 8'h12;
  localparam logic [7:0]  IF_B_FIRST      = 8'h20;
  localparam logic [7:0]  IF_B_LAST       = 8'h2a;
  localparam int          IRQ_FLAG_BIT    = 4;
  localparam int          CCE_BIT         = 6;
  localparam logic [15:0] CONTROL_RESET   = 16'h0001;
  localparam logic [15:0] BIT_TIMING_RST  = 16'h2301;
  localparam logic [7:0]  DATA_LOW_RESET  = 8'h01;
  localparam logic [7:0]  INDEX_RESET     = 8'h00;
endpackage
`default_nettype wire

// ===== core/cirp_timing_reg.sv
// bit timing storage, write-gated by the config change enable
// assumes commit strobe comes from the index port
`default_nettype none
module cirp_timing_reg
  import cirp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // write side
  input  wire logic        wr_en,
  input  wire logic        cce,
  input  wire logic [15:0] wr_data,
  // stored value
  output logic      [15:0] value
);
  logic [15:0] value_reg;
  logic [15:0] value_next;
  // writes outside configuration mode are dropped silently
  assign value_next = (wr_en && cce) ? wr_data : value_reg;
  always_ff @(posedge clock) begin
    if (!nrst) value_reg <= BIT_TIMING_RST;
    else value_reg <= value_next;
  end
  assign value = value_reg;

  a_timing_gated: assert property (@(posedge clock) disable iff (!nrst)
    (wr_en && !cce) |=> $stable(value_reg)) else $error("timing changed without enable");
endmodule // cirp_timing_reg
`default_nettype wire

// ===== core/cirp_port.sv
// indexed register port: special-function bus on one side, controller register bus on the other
// assumes one access per cycle, reads answered next cycle, controller read data combinational
`default_nettype none
module cirp_port
  import cirp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // special-function bus
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_page,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // controller register bus
  output logic      [7:0]  ctl_index,
  output logic             ctl_wr,
  output logic      [15:0] ctl_wdata,
  input  wire logic [15:0] ctl_rdata,
  // controller interrupt summary
  input  wire logic        ctl_irq_pending,
  // configuration seen by the protocol engine
  output logic      [15:0] bit_timing,
  output logic      [7:0]  control_out
);
  logic [7:0]  index_reg,   index_next;
  logic [7:0]  high_reg,    high_next;
  logic [7:0]  low_reg,     low_next;
  logic [7:0]  control_reg, control_next;
  logic [7:0]  status_reg,  status_next;
  logic [7:0]  test_reg,    test_next;
  logic        irq_reg;
  logic [7:0]  rdata_reg,   rdata_next;
  logic        hit_reg;
  logic        wr_reg;
  logic [15:0] wword_reg;
  logic [7:0]  cidx_reg;
  logic [15:0] timing_q;

  // address decode, page 1 only
  wire on_page   = (sfr_page == SFR_PAGE_CAN);
  wire sel_low   = on_page && (sfr_addr == SFR_DATA_LOW);
  wire sel_high  = on_page && (sfr_addr == SFR_DATA_HIGH);
  wire sel_index = on_page && (sfr_addr == SFR_INDEX);
  wire sel_test  = on_page && (sfr_addr == SFR_TEST);
  wire sel_stat  = on_page && (sfr_addr == SFR_STATUS);
  wire sel_ctrl  = on_page && (sfr_addr == SFR_CONTROL);
  wire any_sel   = sel_low | sel_high | sel_index | sel_test | sel_stat | sel_ctrl;

  // commit happens on a low-byte write with the held high byte
  wire        commit   = sfr_wr && sel_low;
  wire [15:0] word_in  = {high_reg, sfr_wdata};
  wire in_if_range = ((index_reg >= IF_A_FIRST) && (index_reg <= IF_A_LAST)) ||
                     ((index_reg >= IF_B_FIRST) && (index_reg <= IF_B_LAST));

  // indexed writes landing on locally held registers
  wire idx_ctrl   = (index_reg == IDX_CONTROL);
  wire idx_stat   = (index_reg == IDX_STATUS);
  wire idx_test   = (index_reg == IDX_TEST);
  wire idx_timing = (index_reg == IDX_BIT_TIMING);

  // pointer: direct write wins, else auto advance inside interface windows
  assign index_next = (sfr_wr && sel_index) ? sfr_wdata :
                      (commit && in_if_range) ? 8'(index_reg + 8'h01) : index_reg;

  assign high_next = (sfr_wr && sel_high) ? sfr_wdata : high_reg;
  assign low_next  = commit ? sfr_wdata : low_reg;

  // control, status and test share one store for both paths; flag bit is never written
  // both paths carry the same byte, so one value serves the direct and the indexed write
  wire [7:0] ctrl_wval = sfr_wdata;
  assign control_next = ((sfr_wr && sel_ctrl) || (commit && idx_ctrl)) ?
                        ((ctrl_wval & ~(8'h01 << IRQ_FLAG_BIT)) | (control_reg & (8'h01 << IRQ_FLAG_BIT)))
                        : control_reg;
  assign status_next  = ((sfr_wr && sel_stat) || (commit && idx_stat)) ? sfr_wdata : status_reg;
  assign test_next    = ((sfr_wr && sel_test) || (commit && idx_test)) ? sfr_wdata : test_reg;

  // local registers read back locally, the rest come from the controller
  wire [15:0] idx_word = idx_ctrl   ? {8'h00, control_reg | {3'h0, irq_reg, 4'h0}} :
                         idx_stat   ? {8'h00, status_reg} :
                         idx_test   ? {8'h00, test_reg} :
                         idx_timing ? timing_q : ctl_rdata;
  assign rdata_next = sel_low   ? idx_word[7:0] :
                      sel_high  ? idx_word[15:8] :
                      sel_index ? index_reg :
                      sel_test  ? test_reg :
                      sel_stat  ? status_reg :
                      sel_ctrl  ? (control_reg | {3'h0, irq_reg, 4'h0}) : 8'h00;

  // storage
  always_ff @(posedge clock) begin
    if (!nrst) begin
      index_reg   <= INDEX_RESET;
      high_reg    <= 8'h00;
      low_reg     <= DATA_LOW_RESET;
      control_reg <= CONTROL_RESET[7:0];
      status_reg  <= 8'h00;
      test_reg    <= 8'h00;
    end else begin
      index_reg   <= index_next;
      high_reg    <= high_next;
      low_reg     <= low_next;
      control_reg <= control_next;
      status_reg  <= status_next;
      test_reg    <= test_next;
    end
  end

  // flag mirrors the controller; no software clear path exists
  always_ff @(posedge clock) begin
    if (!nrst) irq_reg <= 1'b0;
    else irq_reg <= ctl_irq_pending;
  end

  // bus answers and controller strobes, all registered
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      wword_reg <= 16'h0000;
      cidx_reg  <= INDEX_RESET;
    end else begin
      rdata_reg <= sfr_rd ? rdata_next : 8'h00;
      hit_reg   <= (sfr_rd || sfr_wr) && any_sel;
      wr_reg    <= commit && !(idx_ctrl || idx_stat || idx_test || idx_timing);
      wword_reg <= commit ? word_in : wword_reg;
      cidx_reg  <= index_reg;
    end
  end

  cirp_timing_reg u_timing (
    .clock   (clock),
    .nrst    (nrst),
    .wr_en   (commit && idx_timing),
    .cce     (control_reg[CCE_BIT]),
    .wr_data (word_in),
    .value   (timing_q)
  );

  assign sfr_rdata   = rdata_reg;
  assign sfr_hit     = hit_reg;
  assign ctl_index   = cidx_reg;
  assign ctl_wr      = wr_reg;
  assign ctl_wdata   = wword_reg;
  assign bit_timing  = timing_q;
  assign control_out = control_reg;

  // pointer steps by one on a low-byte write inside the interface windows
  a_index_advance: assert property (@(posedge clock) disable iff (!nrst)
    (commit && in_if_range && !(sfr_wr && sel_index)) |=> (index_reg == $past(index_reg) + 8'h01))
    else $error("pointer did not advance");
  // outside the windows a low-byte write leaves the pointer alone
  a_index_hold: assert property (@(posedge clock) disable iff (!nrst)
    (commit && !in_if_range) |=> $stable(index_reg))
    else $error("pointer moved outside range");
  // direct pointer write lands as written
  a_index_write: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_wr && sel_index) |=> (index_reg == $past(sfr_wdata)))
    else $error("pointer write lost");
  // controller sees the pointer one cycle late, never a stale older one
  a_ctl_index: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> (ctl_index == $past(index_reg)))
    else $error("controller index wrong");
  // software can never move the flag bit of the stored control byte
  a_flag_ro: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_wr && sel_ctrl) |=> (control_reg[IRQ_FLAG_BIT] == $past(control_reg[IRQ_FLAG_BIT])))
    else $error("flag bit written");
  // the other control bits take the written byte
  a_ctrl_direct: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_wr && sel_ctrl) |=> (control_reg == (($past(sfr_wdata) & ~(8'h01 << IRQ_FLAG_BIT)) |
                                              ($past(control_reg) & (8'h01 << IRQ_FLAG_BIT)))))
    else $error("control write wrong");
  // flag reads back what the controller reported
  a_flag_read: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_rd && sel_ctrl) |=> (sfr_rdata[IRQ_FLAG_BIT] == $past(irq_reg)))
    else $error("flag read wrong");
  // flag tracks the controller level every cycle, so it clears only when the controller does
  a_flag_follow: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> (irq_reg == $past(ctl_irq_pending)))
    else $error("flag lost");
  // non-local indices get the full word forwarded
  a_commit_word: assert property (@(posedge clock) disable iff (!nrst)
    (commit && !idx_ctrl && !idx_stat && !idx_test && !idx_timing) |=> (ctl_wr && ctl_wdata == $past(word_in)))
    else $error("word not committed");
  // local indices stay inside the port
  a_local_quiet: assert property (@(posedge clock) disable iff (!nrst)
    (commit && (idx_ctrl || idx_stat || idx_test || idx_timing)) |=> !ctl_wr)
    else $error("local write forwarded");
  // high byte is captured and then held until rewritten
  a_high_held: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_wr && sel_high) |=> (high_reg == $past(sfr_wdata)))
    else $error("high byte not captured");
  a_high_stay: assert property (@(posedge clock) disable iff (!nrst)
    !(sfr_wr && sel_high) |=> $stable(high_reg))
    else $error("high byte drifted");
  // indexed and direct test writes reach one store
  a_shared_store: assert property (@(posedge clock) disable iff (!nrst)
    (commit && idx_test) |=> (test_reg == $past(sfr_wdata)))
    else $error("indexed test write lost");
  a_status_direct: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_wr && sel_stat) |=> (status_reg == $past(sfr_wdata)))
    else $error("status write lost");
  a_status_read: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_rd && sel_stat) |=> (sfr_rdata == $past(status_reg)))
    else $error("status read wrong");
  a_test_read: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_rd && sel_test) |=> (sfr_rdata == $past(test_reg)))
    else $error("test read wrong");
  // low-byte address decodes on page 1
  a_decode_low: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_wr && sfr_page == SFR_PAGE_CAN && sfr_addr == 8'hd8) |=> (low_reg == $past(sfr_wdata)))
    else $error("low byte decode wrong");
  // every decoded access answers with a hit pulse, anything else stays quiet
  a_hit_pulse: assert property (@(posedge clock) disable iff (!nrst)
    ((sfr_rd || sfr_wr) && any_sel) |=> sfr_hit)
    else $error("hit missing");
  a_miss_quiet: assert property (@(posedge clock) disable iff (!nrst)
    !((sfr_rd || sfr_wr) && any_sel) |=> !sfr_hit)
    else $error("hit without access");
  // read data is zero except in the cycle after a read, so a stale byte cannot be taken
  a_read_idle: assert property (@(posedge clock) disable iff (!nrst)
    !sfr_rd |=> (sfr_rdata == 8'h00))
    else $error("read data not idle");
  a_index_read: assert property (@(posedge clock) disable iff (!nrst)
    (sfr_rd && sel_index) |=> (sfr_rdata == $past(index_reg)))
    else $error("pointer read wrong");
endmodule // cirp_port
`default_nettype wire

// ===== test/cirp_ctl_model.sv
// behavioural controller register bank behind the index port
// assumes words are committed by ctl_wr at the index shown on ctl_index
`default_nettype none
module cirp_ctl_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // controller register bus
  input  wire logic [7:0]  ctl_index,
  input  wire logic        ctl_wr,
  input  wire logic [15:0] ctl_wdata,
  output logic      [15:0] ctl_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [256];
  // read is combinational, as the port expects it
  assign ctl_rdata = mem[ctl_index];
  // store committed words; cleared on reset so stale data cannot mask a missed commit
  always @(posedge clock) begin
    if (!nrst) begin
      foreach (mem[i]) mem[i] <= 16'h0000;
    end else if (ctl_wr) begin
      mem[ctl_index] <= ctl_wdata;
    end
  end
endmodule // cirp_ctl_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the indexed controller register port
// assumes the host side is driven here and the controller bank is cirp_ctl_model
`default_nettype none
module tb_top;
  import cirp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, ctl_irq_pending = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata, ctl_index, control_out;
  logic sfr_hit, ctl_wr;
  logic [15:0] ctl_wdata, ctl_rdata, bit_timing, rd_q, hit_q, cw_q, cwd_q, w, v;
  int bad_count = 0, n_checks = 0, seed = 32'h6296fa24, m [256];
  logic [7:0] starts [4] = '{8'h07, 8'h12, 8'h13, 8'h2a};
  cirp_port dut_u (.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ctl_index(ctl_index),
    .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .ctl_irq_pending(ctl_irq_pending),
    .bit_timing(bit_timing), .control_out(control_out));
  cirp_ctl_model ctl_u (.clock(clock), .nrst(nrst), .ctl_index(ctl_index), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata));
  // 20 MHz clock
  always #25 clock = ~clock;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      bad_count++;
    end
  endtask
  // one access, held until the taking edge; a gap cycle follows so strobes never toggle twice
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [7:0] pg = SFR_PAGE_CAN);
    @(posedge clock);
    sfr_addr <= a; sfr_page <= pg; sfr_wr <= wr; sfr_rd <= !wr; sfr_wdata <= d;
    @(posedge clock);
    sfr_wr <= 1'b0; sfr_rd <= 1'b0;
    #1 rd_q = {8'h00, sfr_rdata}; hit_q = {15'h0, sfr_hit}; cw_q = {15'h0, ctl_wr}; cwd_q = ctl_wdata;
  endtask
  task automatic put(input logic [7:0] idx, input logic [15:0] d);
    acc(1'b1, SFR_INDEX, idx); acc(1'b1, SFR_DATA_HIGH, d[15:8]); acc(1'b1, SFR_DATA_LOW, d[7:0]);
  endtask
  task automatic get(input logic [7:0] idx, output logic [15:0] d);
    acc(1'b1, SFR_INDEX, idx); acc(1'b0, SFR_DATA_HIGH, 8'h00); d[15:8] = rd_q[7:0];
    acc(1'b0, SFR_DATA_LOW, 8'h00); d[7:0] = rd_q[7:0];
  endtask
  // watchdog sized far above the roughly 200 cycles the sequence needs
  initial begin
    #2500000 bad_count++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    acc(1'b0, SFR_INDEX, 8'h00); chk("index reset", rd_q, 16'h0000);
    chk("hit mapped", hit_q, 16'h0001);
    acc(1'b0, SFR_DATA_LOW, 8'h00); chk("data low reset", rd_q, 16'h0001);
    acc(1'b0, SFR_CONTROL, 8'h00); chk("control reset", rd_q, 16'h0001);
    get(IDX_BIT_TIMING, v); chk("timing reset", v, 16'h2301);
    put(IDX_BIT_TIMING, 16'h5566); repeat (2) @(posedge clock);
    #1 chk("timing locked", bit_timing, 16'h2301);
    put(IDX_CONTROL, 16'h0041); chk("local no commit", cw_q, 16'h0000);
    acc(1'b0, SFR_CONTROL, 8'h00); chk("control direct", rd_q, 16'h0041);
    chk("control out", {8'h00, control_out}, 16'h0041);
    put(IDX_BIT_TIMING, 16'h1234); repeat (2) @(posedge clock);
    #1 chk("timing open", bit_timing, 16'h1234);
    w = 16'($random(seed)); acc(1'b1, SFR_TEST, w[7:0]);
    get(IDX_TEST, v); chk("test indexed", {8'h00, v[7:0]}, {8'h00, w[7:0]});
    w = 16'($random(seed)); acc(1'b1, SFR_STATUS, w[7:0]);
    get(IDX_STATUS, v); chk("status indexed", {8'h00, v[7:0]}, {8'h00, w[7:0]});
    // back-to-back burst across the whole second interface window
    acc(1'b1, SFR_INDEX, IF_B_FIRST);
    for (int i = 0; i < 11; i++) begin
      w = 16'($random(seed)); m[32 + i] = w;
      acc(1'b1, SFR_DATA_HIGH, w[15:8]); acc(1'b1, SFR_DATA_LOW, w[7:0]);
      chk("burst commit", cwd_q, w);
    end
    acc(1'b0, SFR_INDEX, 8'h00); chk("burst end", rd_q, 16'h002b);
    get(8'h25, v); chk("burst readback", v, 16'(m[37]));
    // range boundaries: advance only inside the two windows
    foreach (starts[i]) begin
      w = 16'($random(seed)); m[starts[i]] = w; put(starts[i], w);
      chk("commit strobe", cw_q, 16'h0001);
      acc(1'b0, SFR_INDEX, 8'h00);
      chk("pointer step", rd_q, {8'h00, starts[i]} + ((starts[i] inside {[8'h08:8'h12], [8'h20:8'h2a]}) ? 16'h1 : 16'h0));
      get(starts[i], v); chk("readback", v, 16'(m[starts[i]]));
    end
    // interrupt flag follows the controller and ignores writes
    ctl_irq_pending <= 1'b1; repeat (2) @(posedge clock);
    acc(1'b1, SFR_CONTROL, 8'h41); acc(1'b0, SFR_CONTROL, 8'h00); chk("flag set", rd_q, 16'h0051);
    ctl_irq_pending <= 1'b0; repeat (2) @(posedge clock);
    acc(1'b1, SFR_CONTROL, 8'h51); acc(1'b0, SFR_CONTROL, 8'h00); chk("flag clear", rd_q, 16'h0041);
    acc(1'b0, SFR_DATA_LOW, 8'h00, 8'h00); chk("other page", rd_q | hit_q, 16'h0000);
    acc(1'b0, 8'h00, 8'h00); chk("unmapped", rd_q | hit_q, 16'h0000);
    // second reset in mid-run must bring back the documented values
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    #1 chk("timing after reset", bit_timing, 16'h2301);
    chk("control out reset", {8'h00, control_out}, 16'h0001);
    acc(1'b0, SFR_INDEX, 8'h00); chk("index after reset", rd_q, 16'h0000);
    acc(1'b0, SFR_CONTROL, 8'h00); chk("control after reset", rd_q, 16'h0001);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
